/* File: shared/pbr_pkg.sv */
package pbr_pkg;
	// Address geometry: a 24-bit storage address, position 8 is bit 23, position 31 is bit 0.
	localparam int ADDR_W = 24;
	localparam int WORD_W = 32;
	localparam int HIGH_ZERO_W = 12;
	localparam int LOW_W = 12;
	localparam int AREA_W = 7;
	localparam int ELEM_W = 4;
	localparam int ID_W = 4;
	localparam int SLOT_COUNT = 10;
	// Bit places of the address fields (positions 8, 9-12 and 13-19).
	localparam int ADDR_POS8_BIT = 23;
	localparam int ADDR_ELEM_HI = 22;
	localparam int ADDR_ELEM_LO = 19;
	localparam int ADDR_AREA_HI = 18;
	localparam int ADDR_AREA_LO = 12;
	// Bit places inside the loaded and stored word (positions 8-19 and 28-31).
	localparam int WORD_POS8_BIT = 23;
	localparam int WORD_ELEM_HI = 22;
	localparam int WORD_ELEM_LO = 19;
	localparam int WORD_AREA_HI = 18;
	localparam int WORD_AREA_LO = 12;
	localparam int WORD_PHYS_HI = 3;
	localparam int WORD_PHYS_LO = 0;
	// Counter values of note.
	localparam logic [ELEM_W-1:0] ELEM_ONE = 4'h1;
	localparam logic [ELEM_W-1:0] ELEM_ZERO = 4'h0;
	localparam logic [ELEM_W-1:0] ELEM_STOP = 4'h9;
	localparam logic [ELEM_W-1:0] SLOT_LIMIT = 4'ha;
	// Reset values.
	localparam logic [AREA_W-1:0] AREA_RESET = 7'h00;
	localparam logic [ID_W-1:0] PHYS_RESET = 4'h0;
	localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 24'h00_0000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_STEP = 2'b01,
		ST_HALT = 2'b10
	} pbr_state_type;
endpackage : pbr_pkg

/* File: src/pbr_base_relocation.sv */
`timescale 1ns/1ps
// Operation
// - Addresses with twelve zero high-order bits are redirected to the preferential area.
// - Position 8 of the base must be zero; a one raises invalid address check.
// - Relocated address ORs the base into zero high bits; input address untouched.
// - Every interrupt and logout access is relocated, plus zero-high program addresses.
// - Logical base holds until a new load-base or an external start.
// - Logical base holds area positions 13-19 and element positions 9-12.
// - Positions 9-12 load a four-bit binary counter used for element stepping.
// - Physical base takes the identifier from slot numbered one above positions 9-12.
// - Physical base written on load-base and when stepping finds a configured element.
// - Preferential access keeps low bits, area from logical, element from physical base.
// - Store-base shows area bits, current counter, and physical base contents.
// - Stepping starts only with inhibit-logout-stop clear and a primary element failure.
// - Each increment moves one storage element, repeated until a configured one is found.
// - Each step tests the next higher slot; the first configured identifier is loaded.
// - Stepping passes nonexistent elements, wraps to the lowest, then continues ascending.
// - After reaching the alternate, stepping is blocked until load-base or external start.
// - Failures after stepping hardstop with element check; state frozen until load-base.
// - With no alternate found, stop at the second 9, counter 0000, hardstop and check.
// - Load-base to an unconfigured slot raises specification interrupt, registers unchanged.
// - Stored word: base in 8-19, identifier in 28-31, positions 0-7 and 20-27 zero.
module pbr_base_relocation (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Translation slots and configuration
	input wire logic [pbr_pkg::SLOT_COUNT*pbr_pkg::ID_W-1:0] slot_id_i,
	input wire logic [pbr_pkg::SLOT_COUNT-1:0] slot_ok_i,
	input wire logic inhibit_logout_stop_bit_i,
	// Load-base instruction, external start and store-base instruction
	input wire logic load_base_instruction_i,
	input wire logic external_start_i,
	input wire logic [pbr_pkg::WORD_W-1:0] load_word_i,
	input wire logic store_base_instruction_i,
	// Access request from the address path
	input wire logic acc_req_i,
	input wire logic acc_fixed_i,
	input wire logic [pbr_pkg::ADDR_W-1:0] acc_addr_i,
	input wire logic psa_fail_i,
	// Formed access
	output logic acc_ready_o,
	output logic out_valid_o,
	output logic out_psa_o,
	output logic [pbr_pkg::ADDR_W-1:0] out_addr_o,
	// Stored word
	output logic store_valid_o,
	output logic [pbr_pkg::WORD_W-1:0] store_word_o,
	// Checks and status
	output logic addr_check_o,
	output logic spec_interrupt_o,
	output logic element_check_o,
	output logic hardstop_o,
	output logic alternate_o,
	output logic stepping_o
);
	typedef struct packed {
		pbr_pkg::pbr_state_type state;
		logic [pbr_pkg::AREA_W-1:0] area;
		logic [pbr_pkg::ELEM_W-1:0] count;
		logic [pbr_pkg::ID_W-1:0] phys;
		logic alt;
		logic seen_stop;
		logic element_check;
		logic spec;
		logic addr_chk;
		logic ready;
		// State decodes are kept as flops so the status outputs come straight from registers.
		logic halt;
		logic stepping;
		logic out_valid;
		logic out_psa;
		logic [pbr_pkg::ADDR_W-1:0] out_addr;
		logic store_valid;
		logic [pbr_pkg::WORD_W-1:0] store_word;
	} pbr_top_type;

	pbr_top_type r_q;
	pbr_top_type r_d;
	logic rst_n;
	logic [pbr_pkg::ELEM_W-1:0] load_elem;
	logic [pbr_pkg::ELEM_W-1:0] step_elem;
	logic [pbr_pkg::ID_W-1:0] load_id;
	logic [pbr_pkg::ID_W-1:0] step_id;
	logic load_ok;
	logic step_ok;
	logic high_zero;
	logic load_bit8;

	pbr_reset_sync u_reset_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.reset_n_o(rst_n)
	);

	assign load_elem = load_word_i[pbr_pkg::WORD_ELEM_HI:pbr_pkg::WORD_ELEM_LO];
	assign load_bit8 = load_word_i[pbr_pkg::WORD_POS8_BIT];
	// The search tests the slot for the value one above the counter, so the next value is formed once here.
	assign step_elem = r_q.count + pbr_pkg::ELEM_ONE;

	pbr_slot_select u_load_slot (
		.elem_i(load_elem),
		.slot_id_i(slot_id_i),
		.slot_ok_i(slot_ok_i),
		.id_o(load_id),
		.ok_o(load_ok)
	);

	// One selector decodes the loaded word, the other the next stepping value.
	pbr_slot_select u_step_slot (
		.elem_i(step_elem),
		.slot_id_i(slot_id_i),
		.slot_ok_i(slot_ok_i),
		.id_o(step_id),
		.ok_o(step_ok)
	);

	assign high_zero = (acc_addr_i[pbr_pkg::ADDR_W-1 -: pbr_pkg::HIGH_ZERO_W] == '0);

	always_comb begin
		r_d = r_q;
		r_d.out_valid = 1'b0;
		r_d.store_valid = 1'b0;
		r_d.spec = 1'b0;
		r_d.addr_chk = 1'b0;
		unique case (r_q.state)
			pbr_pkg::ST_IDLE: begin
				if (psa_fail_i) begin
					if (r_q.alt) begin
						r_d.state = pbr_pkg::ST_HALT;
						r_d.element_check = 1'b1;
					end else if (!inhibit_logout_stop_bit_i) begin
						r_d.state = pbr_pkg::ST_STEP;
						r_d.seen_stop = (r_q.count == pbr_pkg::ELEM_STOP);
					end
				end else if (acc_req_i) begin
					r_d.out_valid = 1'b1;
					if (high_zero || acc_fixed_i) begin
						r_d.out_psa = 1'b1;
						r_d.out_addr = acc_addr_i;
						r_d.out_addr[pbr_pkg::ADDR_POS8_BIT] = 1'b0;
						r_d.out_addr[pbr_pkg::ADDR_ELEM_HI:pbr_pkg::ADDR_ELEM_LO] = r_q.phys;
						// Zero-detected area bits are zero, so the OR leaves the base; fixed accesses take it too.
						r_d.out_addr[pbr_pkg::ADDR_AREA_HI:pbr_pkg::ADDR_AREA_LO] = r_q.area;
					end else begin
						r_d.out_psa = 1'b0;
						r_d.out_addr = acc_addr_i;
					end
				end
			end
			pbr_pkg::ST_STEP: begin
				r_d.count = step_elem;
				if (step_ok) begin
					r_d.phys = step_id;
					r_d.alt = 1'b1;
					r_d.state = pbr_pkg::ST_IDLE;
				end else if (step_elem == pbr_pkg::ELEM_STOP) begin
					if (r_q.seen_stop) begin
						r_d.count = pbr_pkg::ELEM_ZERO;
						r_d.element_check = 1'b1;
						r_d.state = pbr_pkg::ST_HALT;
					end else begin
						r_d.seen_stop = 1'b1;
					end
				end
			end
			pbr_pkg::ST_HALT: begin
				r_d.state = pbr_pkg::ST_HALT;
			end
			default: begin
				r_d.state = pbr_pkg::ST_IDLE;
			end
		endcase
		if (store_base_instruction_i) begin
			r_d.store_valid = 1'b1;
			r_d.store_word = pbr_pkg::WORD_ZERO;
			r_d.store_word[pbr_pkg::WORD_ELEM_HI:pbr_pkg::WORD_ELEM_LO] = r_q.count;
			r_d.store_word[pbr_pkg::WORD_AREA_HI:pbr_pkg::WORD_AREA_LO] = r_q.area;
			r_d.store_word[pbr_pkg::WORD_PHYS_HI:pbr_pkg::WORD_PHYS_LO] = r_q.phys;
		end
		// A load wins over stepping and failure in one cycle; an external start cannot leave hardstop.
		if (load_base_instruction_i || (external_start_i && r_q.state != pbr_pkg::ST_HALT)) begin
			if (load_bit8) begin
				r_d.addr_chk = 1'b1;
			end else if (!load_ok) begin
				r_d.spec = 1'b1;
			end else begin
				r_d.area = load_word_i[pbr_pkg::WORD_AREA_HI:pbr_pkg::WORD_AREA_LO];
				r_d.count = load_elem;
				r_d.phys = load_id;
				r_d.alt = 1'b0;
				r_d.element_check = 1'b0;
				r_d.out_valid = 1'b0;
				r_d.state = pbr_pkg::ST_IDLE;
			end
		end
		r_d.ready = (r_d.state == pbr_pkg::ST_IDLE);
		r_d.halt = (r_d.state == pbr_pkg::ST_HALT);
		r_d.stepping = (r_d.state == pbr_pkg::ST_STEP);
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			r_q.state <= pbr_pkg::ST_IDLE;
			r_q.area <= pbr_pkg::AREA_RESET;
			r_q.count <= pbr_pkg::ELEM_ZERO;
			r_q.phys <= pbr_pkg::PHYS_RESET;
			r_q.alt <= 1'b0;
			r_q.seen_stop <= 1'b0;
			r_q.element_check <= 1'b0;
			r_q.spec <= 1'b0;
			r_q.addr_chk <= 1'b0;
			r_q.ready <= 1'b0;
			r_q.halt <= 1'b0;
			r_q.stepping <= 1'b0;
			r_q.out_valid <= 1'b0;
			r_q.out_psa <= 1'b0;
			r_q.out_addr <= pbr_pkg::ADDR_ZERO;
			r_q.store_valid <= 1'b0;
			r_q.store_word <= pbr_pkg::WORD_ZERO;
		end else begin
			r_q <= r_d;
		end
	end

	assign acc_ready_o = r_q.ready;
	assign out_valid_o = r_q.out_valid;
	assign out_psa_o = r_q.out_psa;
	assign out_addr_o = r_q.out_addr;
	assign store_valid_o = r_q.store_valid;
	assign store_word_o = r_q.store_word;
	assign addr_check_o = r_q.addr_chk;
	assign spec_interrupt_o = r_q.spec;
	assign element_check_o = r_q.element_check;
	assign hardstop_o = r_q.halt;
	assign alternate_o = r_q.alt;
	assign stepping_o = r_q.stepping;

	logic plain_load;
	assign plain_load = load_base_instruction_i && !load_bit8 && load_ok;

	sequence s_idle_access;
		acc_req_i && !psa_fail_i && r_q.state == pbr_pkg::ST_IDLE && !load_base_instruction_i && !external_start_i;
	endsequence

	sequence s_step_start;
		r_q.state == pbr_pkg::ST_IDLE && psa_fail_i && !r_q.alt && !inhibit_logout_stop_bit_i
			&& !load_base_instruction_i && !external_start_i;
	endsequence

	a_zero_detect_psa: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_idle_access ##0 high_zero |=> out_valid_o && out_psa_o)
		else $error("zero-high address not relocated");

	a_high_addr_pass: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_idle_access ##0 (!high_zero && !acc_fixed_i) |=> out_valid_o && !out_psa_o
			&& out_addr_o == $past(acc_addr_i))
		else $error("non-preferential address altered");

	a_or_forming: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_idle_access ##0 (high_zero || acc_fixed_i) |=>
			out_addr_o[pbr_pkg::ADDR_ELEM_HI:pbr_pkg::ADDR_ELEM_LO] == $past(r_q.phys)
			&& out_addr_o[pbr_pkg::LOW_W-1:0] == $past(acc_addr_i[pbr_pkg::LOW_W-1:0]))
		else $error("preferential address formed wrongly");

	a_bit8_check: assert property (@(posedge clk_i) disable iff (!rst_n)
		load_base_instruction_i && load_bit8 |=> addr_check_o && $stable(r_q.area))
		else $error("position 8 set without address check");

	a_spec_abort: assert property (@(posedge clk_i) disable iff (!rst_n)
		load_base_instruction_i && !load_bit8 && !load_ok |=> spec_interrupt_o && $stable(r_q.phys)
			&& $stable(r_q.count))
		else $error("bad load-base changed registers");

	a_load_translate: assert property (@(posedge clk_i) disable iff (!rst_n)
		plain_load |=> r_q.phys == $past(load_id) && r_q.count == $past(load_elem) && !alternate_o)
		else $error("load-base did not translate element");

	a_area_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
		!load_base_instruction_i && !external_start_i |=> $stable(r_q.area))
		else $error("logical area changed without load");

	a_store_layout: assert property (@(posedge clk_i) disable iff (!rst_n)
		store_base_instruction_i |=> store_valid_o && store_word_o[31:24] == '0 && store_word_o[11:4] == '0
			&& store_word_o[pbr_pkg::WORD_PHYS_HI:pbr_pkg::WORD_PHYS_LO] == $past(r_q.phys))
		else $error("stored word layout wrong");

	// From a zero start the search takes nine steps to the first stop value and sixteen more.
	a_step_bounded: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_step_start |=> stepping_o && !acc_ready_o ##[1:25] !stepping_o)
		else $error("stepping search not bounded");

	a_alt_blocks: assert property (@(posedge clk_i) disable iff (!rst_n)
		r_q.state == pbr_pkg::ST_IDLE && alternate_o && psa_fail_i && !load_base_instruction_i
			&& !external_start_i |=> hardstop_o && element_check_o && !stepping_o)
		else $error("failure after alternate did not hardstop");

	a_halt_frozen: assert property (@(posedge clk_i) disable iff (!rst_n)
		hardstop_o && !load_base_instruction_i |=> hardstop_o && $stable(r_q.count) && $stable(r_q.phys))
		else $error("hardstop state not frozen");

	a_stop_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
		stepping_o && r_q.seen_stop && step_elem == pbr_pkg::ELEM_STOP && !step_ok && !load_base_instruction_i
			&& !external_start_i |=> hardstop_o && r_q.count == pbr_pkg::ELEM_ZERO && element_check_o)
		else $error("second stop value did not end stepping");

	sequence s_step_cycle;
		stepping_o && !load_base_instruction_i && !external_start_i;
	endsequence

	a_area_form: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_idle_access ##0 (high_zero || acc_fixed_i) |=> !out_addr_o[pbr_pkg::ADDR_POS8_BIT]
			&& out_addr_o[pbr_pkg::ADDR_AREA_HI:pbr_pkg::ADDR_AREA_LO] == $past(r_q.area))
		else $error("preferential area bits formed wrongly");

	a_ext_start_load: assert property (@(posedge clk_i) disable iff (!rst_n)
		external_start_i && !load_base_instruction_i && !hardstop_o && !load_bit8 && load_ok |=>
			r_q.area == $past(load_word_i[pbr_pkg::WORD_AREA_HI:pbr_pkg::WORD_AREA_LO])
			&& r_q.count == $past(load_elem))
		else $error("external start did not load the base");

	a_store_fields: assert property (@(posedge clk_i) disable iff (!rst_n)
		store_base_instruction_i |=>
			store_word_o[pbr_pkg::WORD_ELEM_HI:pbr_pkg::WORD_ELEM_LO] == $past(r_q.count)
			&& store_word_o[pbr_pkg::WORD_AREA_HI:pbr_pkg::WORD_AREA_LO] == $past(r_q.area))
		else $error("stored base fields wrong");

	a_step_count: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_step_cycle ##0 (!r_q.seen_stop || step_elem != pbr_pkg::ELEM_STOP || step_ok) |=>
			r_q.count == $past(step_elem))
		else $error("stepping did not advance one element");

	a_step_found: assert property (@(posedge clk_i) disable iff (!rst_n)
		s_step_cycle ##0 step_ok |=> alternate_o && !stepping_o && r_q.phys == $past(step_id))
		else $error("configured slot not taken");

	a_inhibit_blocks: assert property (@(posedge clk_i) disable iff (!rst_n)
		r_q.state == pbr_pkg::ST_IDLE && psa_fail_i && !alternate_o && inhibit_logout_stop_bit_i
			&& !load_base_instruction_i && !external_start_i |=> !stepping_o && !hardstop_o)
		else $error("stepping started while inhibited");

	a_ready_busy: assert property (@(posedge clk_i) disable iff (!rst_n)
		stepping_o || hardstop_o |-> !acc_ready_o)
		else $error("accesses taken while busy");
endmodule : pbr_base_relocation

/* File: src/pbr_reset_sync.sv */
`timescale 1ns/1ps
module pbr_reset_sync (
	// Clock and raw reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Released reset
	output logic reset_n_o
);
	typedef struct packed {
		logic stage1;
		logic stage2;
	} pbr_sync_type;

	pbr_sync_type s_q;
	pbr_sync_type s_d;

	always_comb begin
		s_d.stage1 = 1'b1;
		s_d.stage2 = s_q.stage1;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign reset_n_o = s_q.stage2;
endmodule : pbr_reset_sync

/* File: src/pbr_slot_select.sv */
`timescale 1ns/1ps
module pbr_slot_select (
	// Logical element value to translate
	input wire logic [pbr_pkg::ELEM_W-1:0] elem_i,
	// Translation slots, slot n+1 at entry n
	input wire logic [pbr_pkg::SLOT_COUNT*pbr_pkg::ID_W-1:0] slot_id_i,
	input wire logic [pbr_pkg::SLOT_COUNT-1:0] slot_ok_i,
	// Selected identifier and whether it names a configured element
	output logic [pbr_pkg::ID_W-1:0] id_o,
	output logic ok_o
);
	logic [pbr_pkg::SLOT_COUNT-1:0] hit;
	logic [pbr_pkg::SLOT_COUNT*pbr_pkg::ID_W-1:0] masked;

	// Value v decodes slot v+1; values above the slot range name no element.
	for (genvar g = 0; g < pbr_pkg::SLOT_COUNT; g++) begin : g_slot
		assign hit[g] = (elem_i == (pbr_pkg::ELEM_W)'(g)) && slot_ok_i[g];
		assign masked[g*pbr_pkg::ID_W +: pbr_pkg::ID_W] =
			(elem_i == (pbr_pkg::ELEM_W)'(g)) ? slot_id_i[g*pbr_pkg::ID_W +: pbr_pkg::ID_W] : '0;
	end

	always_comb begin
		id_o = '0;
		for (int i = 0; i < pbr_pkg::SLOT_COUNT; i++) begin
			id_o = id_o | masked[i*pbr_pkg::ID_W +: pbr_pkg::ID_W];
		end
		ok_o = |hit;
	end
endmodule : pbr_slot_select

/* File: tb/pbr_base_relocation_bench.sv */
`timescale 1ns/1ps
module pbr_base_relocation_bench;
	logic clk, rst_n, inh, ld, ext, st, req, fx, fail;
	logic [9:0] cfg_ok, s_ok;
	logic [15:0] mask;
	logic [39:0] s_id;
	logic [31:0] lw, sw;
	logic [23:0] a, oa;
	logic rdy, ov, op, sv, ac, si, element_check, hs, alt, stp;
	int n_errors = 0;
	int checks = 0;

	pbr_base_relocation i_dut (.clk_i(clk), .reset_n_i(rst_n), .slot_id_i(s_id), .slot_ok_i(s_ok),
		.inhibit_logout_stop_bit_i(inh), .load_base_instruction_i(ld), .external_start_i(ext),
		.load_word_i(lw), .store_base_instruction_i(st), .acc_req_i(req), .acc_fixed_i(fx),
		.acc_addr_i(a), .psa_fail_i(fail), .acc_ready_o(rdy), .out_valid_o(ov), .out_psa_o(op),
		.out_addr_o(oa), .store_valid_o(sv), .store_word_o(sw), .addr_check_o(ac),
		.spec_interrupt_o(si), .element_check_o(element_check), .hardstop_o(hs), .alternate_o(alt),
		.stepping_o(stp));
	pbr_far_model i_far (.clk_i(clk), .reset_n_i(rst_n), .cfg_ok_i(cfg_ok), .fail_mask_i(mask),
		.out_valid_i(ov), .out_psa_i(op), .out_addr_i(oa), .slot_id_o(s_id), .slot_ok_o(s_ok),
		.psa_fail_o(fail));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] wd(logic [3:0] c, logic [6:0] ar, logic [3:0] p);
		return {8'h00, 1'b0, c, ar, 8'h00, p};
	endfunction : wd

	function automatic logic [23:0] rl(logic [3:0] p, logic [6:0] ar, logic [11:0] lo);
		return {1'b0, p, ar, lo};
	endfunction : rl

	task automatic step();
		@(posedge clk);
		#1;
	endtask : step

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : chk

	// Waits until the block accepts accesses again or has halted.
	task automatic wait_idle();
		int i;
		i = 0;
		while (rdy !== 1'b1 && hs !== 1'b1 && i < 24) begin
			step();
			i++;
		end
		if (i == 24) begin
			n_errors++;
			$display("mismatch at %0t: block stays busy", $time);
			give_verdict();
		end
	endtask : wait_idle

	task automatic load(input logic e, input logic [31:0] w);
		lw = w;
		ld = !e;
		ext = e;
		step();
		ld = 1'b0;
		ext = 1'b0;
	endtask : load

	task automatic store_chk(input logic [31:0] exp);
		st = 1'b1;
		step();
		st = 1'b0;
		chk(sv, 1, "store not answered");
		chk(sw, exp, "stored word");
	endtask : store_chk

	task automatic access(input logic [23:0] ad, input logic f);
		wait_idle();
		req = 1'b1;
		a = ad;
		fx = f;
		step();
		req = 1'b0;
		fx = 1'b0;
		chk(ov, 1, "access not answered");
	endtask : access

	task automatic fail_wait();
		access(24'h00_0038, 1'b0);
		step();
		step();
	endtask : fail_wait

	initial begin
		{rst_n, inh, ld, ext, st, req, fx, cfg_ok, mask, lw, a} = '0;
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (6) step();
		chk(rdy, 1, "not ready after reset");
		store_chk(32'h0000_0000);
		load(1'b0, 32'h0080_0000 | wd(4'h1, 7'h05, 4'h0));
		chk(ac, 1, "position 8 not checked");
		store_chk(32'h0000_0000);
		cfg_ok = 10'h00a;
		load(1'b0, wd(4'h2, 7'h05, 4'h0));
		chk(si, 1, "unconfigured slot loaded");
		load(1'b0, wd(4'h1, 7'h05, 4'h0));
		chk({ac, si}, 0, "good load flagged");
		store_chk(wd(4'h1, 7'h05, 4'he));
		$display("test loads done");
		access(24'h00_0038, 1'b0);
		chk(op, 1, "zero high not relocated");
		chk(oa, rl(4'he, 7'h05, 12'h038), "relocated address");
		access(24'h12_3456, 1'b0);
		chk(op, 0, "plain address relocated");
		access(24'h12_3456, 1'b1);
		chk(op, 1, "fixed access not relocated");
		chk(oa, rl(4'he, 7'h05, 12'h456), "fixed address");
		$display("test relocation done");
		inh = 1'b1;
		mask = 16'h4000;
		fail_wait();
		step();
		chk({stp, rdy}, 1, "stepping while inhibited");
		inh = 1'b0;
		fail_wait();
		chk({stp, rdy}, 2, "stepping not started");
		wait_idle();
		chk(alt, 1, "alternate not reached");
		store_chk(wd(4'h3, 7'h05, 4'hc));
		mask = 16'h5000;
		access(24'h00_0040, 1'b0);
		chk(oa, rl(4'hc, 7'h05, 12'h040), "alternate address");
		step();
		step();
		chk({hs, element_check, stp}, 6, "no hardstop at alternate");
		load(1'b1, wd(4'h1, 7'h05, 4'h0));
		store_chk(wd(4'h3, 7'h05, 4'hc));
		mask = 16'h0000;
		load(1'b0, wd(4'h1, 7'h05, 4'h0));
		chk({element_check, alt}, 0, "check not cleared by load");
		step();
		load(1'b1, wd(4'h3, 7'h11, 4'h0));
		store_chk(wd(4'h3, 7'h11, 4'hc));
		$display("test stepping done");
		cfg_ok = 10'h102;
		load(1'b0, wd(4'h8, 7'h05, 4'h0));
		mask = 16'h0080;
		fail_wait();
		wait_idle();
		chk(alt, 1, "no alternate after wrap");
		store_chk(wd(4'h1, 7'h05, 4'he));
		cfg_ok = 10'h200;
		load(1'b0, wd(4'h9, 7'h05, 4'h0));
		cfg_ok = 10'h000;
		mask = 16'h0040;
		fail_wait();
		wait_idle();
		chk({hs, element_check}, 3, "no hardstop without alternate");
		store_chk(wd(4'h0, 7'h05, 4'h6));
		$display("test wrap done");
		give_verdict();
	end
endmodule : pbr_base_relocation_bench

/* File: tb/pbr_far_model.sv */
`timescale 1ns/1ps
module pbr_far_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Configuration and broken elements chosen by the bench
	input wire logic [9:0] cfg_ok_i,
	input wire logic [15:0] fail_mask_i,
	// Formed access from the block
	input wire logic out_valid_i,
	input wire logic out_psa_i,
	input wire logic [23:0] out_addr_i,
	// Translation slots and failure report
	output logic [39:0] slot_id_o,
	output logic [9:0] slot_ok_o,
	output logic psa_fail_o
);
	// Slot n+1 holds identifier 15-n, so every slot names a distinct element.
	always_comb begin
		for (int n = 0; n < 10; n++) begin
			slot_id_o[4*n+:4] = 4'hf - 4'(n);
		end
	end
	assign slot_ok_o = cfg_ok_i;
	// A preferential access to a broken element is answered by a failure one cycle later.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			psa_fail_o <= 1'b0;
		end else begin
			psa_fail_o <= out_valid_i && out_psa_i && fail_mask_i[out_addr_i[22:19]];
		end
	end
endmodule : pbr_far_model
